//--- logic/secwr_pkg.sv
package secwr_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 20;
   localparam int PROG_TIME_US = 5000;
   localparam int PROG_CYCLES_DEF = PROG_TIME_US * CLK_MHZ;
   localparam int POR_TIME_US = 100;
   localparam int POR_CYCLES = POR_TIME_US * CLK_MHZ;
   localparam int PROG_CNT_W = 24;
   localparam int POR_CNT_W = 16;

   // ----------------------------------------------------------------
   // Sizes and reset values
   // ----------------------------------------------------------------
   localparam int BUF_DEPTH = 16;
   localparam int IDX_W = 4;
   localparam int CSUM_BYTES = 2;
   localparam int CSUM_W = 8 * CSUM_BYTES;
   localparam int SENSOR_N = 3;
   localparam logic AUTH_RST = 1'b0;
   localparam logic [7:0] ADDR_RST = 8'h00;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      EV_WR_CMD = 3'h0,
      EV_DATA = 3'h1,
      EV_CSUM_CMD = 3'h2,
      EV_OTHER_CMD = 3'h3,
      EV_STOP = 3'h4
   } ev_kind_type;

   typedef struct packed {
      ev_kind_type kind;
      logic [7:0] data;
   } link_ev_type;

   typedef struct packed {
      logic we;
      logic [7:0] addr;
      logic [7:0] data;
   } mem_wr_type;

   typedef enum logic [7:0] {
      S_POR = 8'h01,
      S_TAMPER = 8'h02,
      S_IDLE = 8'h04,
      S_FILL = 8'h08,
      S_WAIT_CSUM = 8'h10,
      S_CSUM = 8'h20,
      S_WRITE = 8'h40,
      S_PROG = 8'h80
   } wr_state_type;

endpackage

//--- logic/link_event_sync.sv
`timescale 1ns/1ps
module link_event_sync (
   input wire logic link_clk_i,
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic lnk_valid_i,
   input wire secwr_pkg::link_ev_type lnk_ev_i,
   output logic lnk_ready_o,
   output logic ev_valid_o,
   output secwr_pkg::link_ev_type ev_o
);

   // ----------------------------------------------------------------
   // State of both domains
   // ----------------------------------------------------------------
   typedef struct packed {
      logic tog;
      logic ack_s1;
      logic ack_s2;
      secwr_pkg::link_ev_type word;
   } lnk_state_type;

   typedef struct packed {
      logic tog_s1;
      logic tog_s2;
      logic tog_s3;
      logic ack;
      logic vld;
      secwr_pkg::link_ev_type word;
   } m_state_type;

   lnk_state_type l_q;
   lnk_state_type l_d;
   m_state_type m_q;
   m_state_type m_d;
   logic lnk_busy;

   // Link side holds the word until the toggle comes back acknowledged
   assign lnk_busy = l_q.tog != l_q.ack_s2;
   assign lnk_ready_o = !lnk_busy;

   // Link domain next state
   always_comb begin
      l_d = l_q;
      l_d.ack_s1 = m_q.ack;
      l_d.ack_s2 = l_q.ack_s1;
      if (lnk_valid_i && !lnk_busy) begin
         l_d.word = lnk_ev_i;
         l_d.tog = !l_q.tog;
      end
   end

   always_ff @(posedge link_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         l_q <= '0;
      end else begin
         l_q <= l_d;
      end
   end

   // Core domain next state; word is stable once the toggle is seen
   always_comb begin
      m_d = m_q;
      m_d.tog_s1 = l_q.tog;
      m_d.tog_s2 = m_q.tog_s1;
      m_d.tog_s3 = m_q.tog_s2;
      m_d.vld = m_q.tog_s2 != m_q.tog_s3;
      if (m_q.tog_s2 != m_q.tog_s3) begin
         m_d.word = l_q.word;
         m_d.ack = m_q.tog_s2;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         m_q <= '0;
      end else begin
         m_q <= m_d;
      end
   end

   assign ev_valid_o = m_q.vld;
   assign ev_o = m_q.word;

endmodule

//--- logic/secure_write_ctrl.sv
`timescale 1ns/1ps
// How it works
// [R1] Secure writes wait in buffer for checksum
// [R2] Host sends checksum right after write
// [R3] Matching checksum programs the buffered data
// [R4] Bad checksum discards data, resets crypto
// [R5] Intervening bus traffic abandons pending write
// [R6] Programming starts at the closing stop
// [R7] Hold off commands after reset delay
// [R8] Reset clears all security flags
// [R9] Voltage, clock, light sensors signal tamper
// [R10] Tamper disables the whole device
// [R11] Programming cycle ends within five milliseconds
// [R12] Reset or tamper discards pending data
module secure_write_ctrl #(
   parameter int PROG_CYCLES = secwr_pkg::PROG_CYCLES_DEF
) (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic link_clk_i,
   input wire logic lnk_valid_i,
   input wire secwr_pkg::link_ev_type lnk_ev_i,
   output logic lnk_ready_o,
   input wire logic volt_fault_i,
   input wire logic clk_fault_i,
   input wire logic light_fault_i,
   input wire logic auth_ok_i,
   input wire logic auth_end_i,
   input wire logic [secwr_pkg::CSUM_W-1:0] mac_i,
   output secwr_pkg::mem_wr_type mem_o,
   output logic crypto_rst_o,
   output logic commit_o,
   output logic abort_o,
   output logic secure_mode_o,
   output logic operational_o,
   output logic tamper_o,
   output logic prog_busy_o
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      secwr_pkg::wr_state_type st;
      logic auth;
      logic secure;
      logic [secwr_pkg::POR_CNT_W-1:0] por_cnt;
      logic [secwr_pkg::PROG_CNT_W-1:0] prog_cnt;
      logic [secwr_pkg::IDX_W:0] cnt;
      logic [secwr_pkg::IDX_W-1:0] idx;
      logic [7:0] addr;
      logic [secwr_pkg::BUF_DEPTH-1:0][7:0] buffer;
      logic [secwr_pkg::CSUM_W-1:0] csum;
      logic [1:0] csum_n;
      logic [secwr_pkg::SENSOR_N-1:0] sens_s1;
      logic [secwr_pkg::SENSOR_N-1:0] sens_s2;
      secwr_pkg::mem_wr_type mem;
      logic crypto_rst;
      logic commit;
      logic abort;
   } ctrl_state_type;

   localparam logic [secwr_pkg::PROG_CNT_W-1:0] PROG_LAST = secwr_pkg::PROG_CNT_W'(PROG_CYCLES - 1);
   localparam logic [secwr_pkg::POR_CNT_W-1:0] POR_LAST = secwr_pkg::POR_CNT_W'(secwr_pkg::POR_CYCLES - 1);
   localparam logic [secwr_pkg::IDX_W:0] BUF_FULL = (secwr_pkg::IDX_W + 1)'(secwr_pkg::BUF_DEPTH);
   localparam logic [1:0] CSUM_FULL = 2'(secwr_pkg::CSUM_BYTES);

   ctrl_state_type q;
   ctrl_state_type d;
   logic ev_valid;
   secwr_pkg::link_ev_type ev;
   logic tamper;

   // ----------------------------------------------------------------
   // Link crossing
   // ----------------------------------------------------------------
   link_event_sync u_sync (
      .link_clk_i(link_clk_i),
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .lnk_valid_i(lnk_valid_i),
      .lnk_ev_i(lnk_ev_i),
      .lnk_ready_o(lnk_ready_o),
      .ev_valid_o(ev_valid),
      .ev_o(ev)
   );

   // Any synchronised sensor trip is a tamper event
   assign tamper = |q.sens_s2; // [R9]

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      d = q;
      d.mem.we = 1'b0;
      d.crypto_rst = 1'b0;
      d.commit = 1'b0;
      d.abort = 1'b0;
      d.sens_s1 = {light_fault_i, clk_fault_i, volt_fault_i}; // [R9]
      d.sens_s2 = q.sens_s1;
      if (auth_ok_i) begin
         d.auth = 1'b1;
      end
      if (auth_end_i) begin
         d.auth = secwr_pkg::AUTH_RST;
      end
      if (tamper) begin
         // Die disabled: drop pending data, clear flags, stop programming
         d.st = secwr_pkg::S_TAMPER; // [R10]
         d.cnt = '0; // [R12]
         d.csum_n = '0;
         d.auth = secwr_pkg::AUTH_RST; // [R8]
         d.secure = 1'b0;
         d.crypto_rst = 1'b1;
         d.por_cnt = '0;
      end else begin
         case (q.st)
            secwr_pkg::S_TAMPER: begin
               d.st = secwr_pkg::S_POR; // [R7]
               d.por_cnt = '0;
            end
            secwr_pkg::S_POR: begin
               // Non-operational until the delay has run out
               if (q.por_cnt == POR_LAST) begin
                  d.st = secwr_pkg::S_IDLE; // [R7]
               end else begin
                  d.por_cnt = q.por_cnt + 1'b1;
               end
               d.auth = secwr_pkg::AUTH_RST; // [R8]
            end
            secwr_pkg::S_IDLE: begin
               if (ev_valid && ev.kind == secwr_pkg::EV_WR_CMD) begin
                  d.addr = ev.data;
                  d.cnt = '0;
                  d.secure = q.auth; // [R1]
                  d.st = secwr_pkg::S_FILL;
               end
            end
            secwr_pkg::S_FILL: begin
               if (ev_valid) begin
                  case (ev.kind)
                     secwr_pkg::EV_DATA: begin
                        if (q.cnt != BUF_FULL) begin
                           d.buffer[q.cnt[secwr_pkg::IDX_W-1:0]] = ev.data; // [R1]
                           d.cnt = q.cnt + 1'b1;
                        end
                     end
                     secwr_pkg::EV_STOP: begin
                        if (q.cnt == '0) begin
                           d.st = secwr_pkg::S_IDLE;
                        end else if (q.secure) begin
                           d.st = secwr_pkg::S_WAIT_CSUM; // [R1]
                        end else begin
                           d.st = secwr_pkg::S_WRITE; // [R6]
                           d.idx = '0;
                           d.commit = 1'b1;
                        end
                     end
                     default: begin
                        d.st = secwr_pkg::S_IDLE;
                        d.abort = 1'b1;
                     end
                  endcase
               end
            end
            secwr_pkg::S_WAIT_CSUM: begin
               // Only the checksum command may follow a buffered write
               if (ev_valid) begin
                  if (ev.kind == secwr_pkg::EV_CSUM_CMD) begin
                     d.st = secwr_pkg::S_CSUM; // [R2]
                     d.csum_n = '0;
                  end else begin
                     d.st = secwr_pkg::S_IDLE; // [R5]
                     d.abort = 1'b1;
                     d.crypto_rst = 1'b1;
                  end
               end
            end
            secwr_pkg::S_CSUM: begin
               if (ev_valid) begin
                  case (ev.kind)
                     secwr_pkg::EV_DATA: begin
                        if (q.csum_n != CSUM_FULL) begin
                           d.csum = {q.csum[secwr_pkg::CSUM_W-9:0], ev.data};
                           d.csum_n = q.csum_n + 1'b1;
                        end
                     end
                     secwr_pkg::EV_STOP: begin
                        if (q.csum_n == CSUM_FULL && q.csum == mac_i) begin
                           d.st = secwr_pkg::S_WRITE; // [R3] [R6]
                           d.idx = '0;
                           d.commit = 1'b1;
                        end else begin
                           d.st = secwr_pkg::S_IDLE; // [R4]
                           d.abort = 1'b1;
                           d.crypto_rst = 1'b1;
                        end
                     end
                     default: begin
                        d.st = secwr_pkg::S_IDLE; // [R5]
                        d.abort = 1'b1;
                        d.crypto_rst = 1'b1;
                     end
                  endcase
               end
            end
            secwr_pkg::S_WRITE: begin
               // One byte per cycle into the array, address wraps
               d.mem.we = 1'b1; // [R3]
               d.mem.addr = q.addr + 8'(q.idx);
               d.mem.data = q.buffer[q.idx];
               d.idx = q.idx + 1'b1;
               if ((secwr_pkg::IDX_W + 1)'(q.idx) == q.cnt - 1'b1) begin
                  d.st = secwr_pkg::S_PROG;
                  d.prog_cnt = '0;
               end
            end
            secwr_pkg::S_PROG: begin
               // Self-timed cycle; bus events are ignored while busy
               if (q.prog_cnt == PROG_LAST) begin
                  d.st = secwr_pkg::S_IDLE; // [R11]
               end else begin
                  d.prog_cnt = q.prog_cnt + 1'b1;
               end
            end
            default: begin
               d.st = secwr_pkg::S_POR;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         q <= '0;
         q.st <= secwr_pkg::S_POR; // [R7] [R12]
         q.auth <= secwr_pkg::AUTH_RST; // [R8]
         q.addr <= secwr_pkg::ADDR_RST;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign mem_o = q.mem;
   assign crypto_rst_o = q.crypto_rst;
   assign commit_o = q.commit;
   assign abort_o = q.abort;
   assign secure_mode_o = q.auth;
   assign operational_o = q.st == secwr_pkg::S_IDLE;
   assign tamper_o = q.st == secwr_pkg::S_TAMPER;
   assign prog_busy_o = (q.st == secwr_pkg::S_WRITE) || (q.st == secwr_pkg::S_PROG);

endmodule

//--- bench/secwr_asserts.sv
`timescale 1ns/1ps
module secwr_asserts #(
   parameter int PROG_CYCLES = 50
) (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic volt_fault_i,
   input wire logic clk_fault_i,
   input wire logic light_fault_i,
   input wire secwr_pkg::mem_wr_type mem_o,
   input wire logic crypto_rst_o,
   input wire logic commit_o,
   input wire logic abort_o,
   input wire logic secure_mode_o,
   input wire logic operational_o,
   input wire logic tamper_o,
   input wire logic prog_busy_o
);
   // ----
   // Checks
   // ----
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   int por_cnt_q;
   int prog_cnt_q;
   // Cycles since reset or tamper, and length of a busy run
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         por_cnt_q <= 0;
         prog_cnt_q <= 0;
      end else begin
         por_cnt_q <= tamper_o ? 0 : por_cnt_q + 1;
         prog_cnt_q <= prog_busy_o ? prog_cnt_q + 1 : 0;
      end
   end
   sequence commit_seq;
      commit_o ##1 mem_o.we;
   endsequence
   commit_we_a: assert property (commit_o |-> commit_seq)
      else $error("No write strobe after commit");
   we_cause_a: assert property ($rose(mem_o.we) |-> $past(commit_o))
      else $error("Write strobe without commit");
   abort_quiet_a: assert property (abort_o |=> !mem_o.we [*4])
      else $error("Write after abort");
   tamper_off_a: assert property (tamper_o |-> !operational_o && !mem_o.we && !commit_o)
      else $error("Activity while tampered");
   sensor_trip_a: assert property ((volt_fault_i || clk_fault_i || light_fault_i) [*4] |-> ##[0:2] tamper_o)
      else $error("Sensor did not trip tamper");
   tamper_crst_a: assert property (tamper_o && $past(tamper_o) |-> crypto_rst_o)
      else $error("Crypto engine not held in reset");
   flags_clear_a: assert property (tamper_o ##1 tamper_o |-> !secure_mode_o)
      else $error("Secure flag kept through tamper");
   por_hold_a: assert property (operational_o |-> por_cnt_q >= secwr_pkg::POR_CYCLES - 3)
      else $error("Operational before start-up delay");
   prog_bound_a: assert property (prog_cnt_q <= PROG_CYCLES + secwr_pkg::BUF_DEPTH + 2)
      else $error("Programming too long");
endmodule

//--- bench/host_link_model.sv
`timescale 1ns/1ps
module host_link_model (
   output logic link_clk_o,
   output logic lnk_valid_o,
   output secwr_pkg::link_ev_type lnk_ev_o,
   input wire logic lnk_ready_i
);
   // ----
   // Host side of the link
   // ----
   initial begin
      link_clk_o = 1'b0;
      lnk_valid_o = 1'b0;
      lnk_ev_o = '0;
   end
   // Clock pulses for the reset phase only
   task automatic tick(input int n);
      repeat (n) begin
         #16 link_clk_o = 1'b1;
         #16 link_clk_o = 1'b0;
      end
   endtask
   // Event held until an edge finds ready; the clock stops after it
   task automatic send(input secwr_pkg::ev_kind_type k, input logic [7:0] d, output logic ok);
      int i;
      // Leaves the released lines one step apart from the next offer
      #4;
      ok = 1'b0;
      lnk_valid_o = 1'b1;
      lnk_ev_o = {k, d};
      for (i = 0; i < 100 && !ok; i++) begin
         #16 ok = lnk_ready_i;
         link_clk_o = 1'b1;
         #1 lnk_valid_o = !ok;
         #15 link_clk_o = 1'b0;
      end
      lnk_ev_o = ~lnk_ev_o; // Released lines show no stale event
   endtask
endmodule

//--- bench/secure_write_ctrl_tb.sv
`timescale 1ns/1ps
module secure_write_ctrl_tb;
   // ----
   // Harness
   // ----
   localparam int PROG_CYCLES = 50;
   logic mclk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [2:0] fault_q = 3'h0;
   logic auth_ok_q = 1'b0;
   logic auth_end_q = 1'b0;
   logic [15:0] mac_q = 16'h0000;
   logic link_clk, lnk_valid, lnk_ready, crst, commit, abort, smode, oper, tamper, busy;
   secwr_pkg::link_ev_type lnk_ev;
   secwr_pkg::mem_wr_type mem;
   int n_errors = 0;
   int checks_done = 0;
   int we_n, commit_n, abort_n, crst_n, cnt;
   logic [7:0] wa [4];
   logic [7:0] wd [4];
   always #25 mclk_i = ~mclk_i;
   host_link_model host_link_model_inst (.link_clk_o(link_clk), .lnk_valid_o(lnk_valid), .lnk_ev_o(lnk_ev),
      .lnk_ready_i(lnk_ready));
   secure_write_ctrl #(.PROG_CYCLES(PROG_CYCLES)) secure_write_ctrl_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
      .link_clk_i(link_clk), .lnk_valid_i(lnk_valid), .lnk_ev_i(lnk_ev), .lnk_ready_o(lnk_ready),
      .volt_fault_i(fault_q[0]), .clk_fault_i(fault_q[1]), .light_fault_i(fault_q[2]), .auth_ok_i(auth_ok_q),
      .auth_end_i(auth_end_q), .mac_i(mac_q), .mem_o(mem), .crypto_rst_o(crst), .commit_o(commit),
      .abort_o(abort), .secure_mode_o(smode), .operational_o(oper), .tamper_o(tamper), .prog_busy_o(busy));
   // Strobe and pulse counts
   always @(posedge mclk_i) begin
      if (mem.we === 1'b1) begin
         wa[we_n % 4] = mem.addr;
         wd[we_n % 4] = mem.data;
         we_n++;
      end
      commit_n += int'(commit === 1'b1);
      abort_n += int'(abort === 1'b1);
      crst_n += int'(crst === 1'b1 && tamper !== 1'b1);
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic ev(input secwr_pkg::ev_kind_type k, input logic [7:0] d);
      logic ok;
      host_link_model_inst.send(k, d, ok);
      check(ok, 1'b1);
   endtask
   task automatic clr;
      #1;
      we_n = 0;
      commit_n = 0;
      abort_n = 0;
      crst_n = 0;
   endtask
   // Cycles until the device accepts commands again, bounded
   task automatic wait_op(input int lim);
      cnt = 0;
      while (oper !== 1'b1 && cnt < lim) begin
         @(posedge mclk_i);
         #1;
         cnt++;
      end
      if (oper !== 1'b1) begin
         n_errors++;
         close_out();
      end
   endtask
   // ----
   // Scenarios
   // ----
   task automatic t_plain;
      clr();
      ev(secwr_pkg::EV_WR_CMD, 8'h10);
      ev(secwr_pkg::EV_DATA, 8'hA5);
      ev(secwr_pkg::EV_DATA, 8'h5A);
      ev(secwr_pkg::EV_STOP, 8'h00);
      // The closing stop still has to cross into the core
      repeat (8) @(posedge mclk_i);
      wait_op(500);
      check(commit_n, 1);
      check({wa[0], wd[0], wa[1], wd[1]}, 32'h10A5115A);
   endtask
   task automatic sec_head;
      @(posedge mclk_i);
      auth_ok_q <= 1'b1;
      @(posedge mclk_i);
      auth_ok_q <= 1'b0;
      clr();
      ev(secwr_pkg::EV_WR_CMD, 8'h20);
      ev(secwr_pkg::EV_DATA, 8'h77);
      ev(secwr_pkg::EV_STOP, 8'h00);
      repeat (20) @(posedge mclk_i);
      mac_q <= 16'hC3E1;
      check(we_n, 0);
      check(smode, 1'b1);
   endtask
   task automatic csum(input logic [7:0] lo);
      ev(secwr_pkg::EV_CSUM_CMD, 8'h00);
      ev(secwr_pkg::EV_DATA, 8'hC3);
      ev(secwr_pkg::EV_DATA, lo);
      ev(secwr_pkg::EV_STOP, 8'h00);
      // The closing stop still has to cross into the core
      repeat (8) @(posedge mclk_i);
      wait_op(500);
   endtask
   task automatic t_good;
      sec_head();
      csum(8'hE1);
      check({we_n[7:0], wa[0], wd[0]}, 24'h012077);
      check(abort_n, 0);
      @(posedge mclk_i);
      auth_end_q <= 1'b1;
      @(posedge mclk_i);
      auth_end_q <= 1'b0;
      repeat (2) @(posedge mclk_i);
      check(smode, 1'b0);
   endtask
   task automatic t_bad;
      sec_head();
      csum(8'hE0);
      check({we_n[7:0], abort_n[7:0], crst_n[7:0]}, 24'h000101);
   endtask
   task automatic t_between;
      sec_head();
      ev(secwr_pkg::EV_OTHER_CMD, 8'h00);
      repeat (8) @(posedge mclk_i);
      wait_op(500);
      check({we_n[7:0], abort_n[7:0], crst_n[7:0]}, 24'h000101);
   endtask
   task automatic t_tamper;
      for (int s = 0; s < 3; s++) begin
         sec_head();
         fault_q <= 3'(1 << s);
         repeat (6) @(posedge mclk_i);
         check({tamper, oper}, 2'h2);
         check(smode, 1'b0);
         fault_q <= 3'h0;
         wait_op(2100);
         check(cnt >= 2000 && cnt <= 2010, 1'b1);
         check(we_n, 0);
      end
   endtask
   initial begin
      fork
         repeat (20) @(posedge mclk_i);
         host_link_model_inst.tick(8);
      join
      rst_b_i <= 1'b1;
      wait_op(2100);
      check(cnt >= 1995 && cnt <= 2005, 1'b1);
      check(smode, 1'b0);
      t_plain();
      t_good();
      t_bad();
      t_between();
      t_tamper();
      close_out();
   end
endmodule
bind secure_write_ctrl secwr_asserts #(.PROG_CYCLES(PROG_CYCLES)) secwr_asserts_inst (.mclk_i(mclk_i),
   .rst_b_i(rst_b_i), .volt_fault_i(volt_fault_i), .clk_fault_i(clk_fault_i), .light_fault_i(light_fault_i),
   .mem_o(mem_o), .crypto_rst_o(crypto_rst_o), .commit_o(commit_o), .abort_o(abort_o),
   .secure_mode_o(secure_mode_o), .operational_o(operational_o), .tamper_o(tamper_o), .prog_busy_o(prog_busy_o));
